/* rtl/csc_top.sv */
// supervisory charge state controller with register access
module csc_top
   import csc_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES,     // aclk cycles per tick
   parameter int SAFETY_TICKS = SAFETY_TICKS_DEF // safety timer default
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // analog conditions
   input wire csc_sense_t sense,
   // power stage
   output csc_power_t power,
   // open-drain supply-valid line
   input wire logic supply_valid_out_i,
   output logic supply_valid_out_o,
   output logic supply_valid_out_oe,
   // open-drain first status line
   input wire logic status_line_first_i,
   output logic status_line_first_o,
   output logic status_line_first_oe,
   // open-drain second status line
   input wire logic status_line_second_i,
   output logic status_line_second_o,
   output logic status_line_second_oe,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // whole module state
   typedef struct packed {
      csc_state_t st;        // controller state
      logic [31:0] presc;    // aclk cycles within a tick
      logic tick;            // one-cycle tick strobe
      logic [15:0] win;      // detection window count, ticks
      logic [31:0] safety;   // safety timer count, ticks
      logic [31:0] limit;    // safety timer limit, ticks
      logic permit_d;        // previous effective permit
      logic soft_permit;     // software permit bit
      csc_power_t pwr;       // power stage outputs
      logic sv_oe;           // supply-valid transistor on
      logic s1_oe;           // first status transistor on
      logic s2_oe;           // second status transistor on
      logic aw_got;          // write address held
      logic w_got;           // write data held
      logic [7:0] awaddr;    // held write address
      logic [31:0] wdata;    // held write data
      logic [3:0] wstrb;     // held write strobes
      logic awready;         // write address ready
      logic wready;          // write data ready
      logic bvalid;          // write response valid
      logic [1:0] bresp;     // write response code
      logic arready;         // read address ready
      logic rvalid;          // read data valid
      logic [1:0] rresp;     // read response code
      logic [31:0] rdata;    // read data
   } csc_regs_t;

   csc_regs_t r_reg;  // registered state
   csc_regs_t r_next; // next state
   csc_sense_t s;     // synchronised conditions
   // address decode shared by read and write
   function automatic csc_rsel_t csc_decode(input logic [7:0] a);
      csc_rsel_t sel;
      sel = RSEL_NONE;
      if (a == OFS_CTRL) begin
         sel = RSEL_CTRL;
      end else if (a == OFS_STATUS) begin
         sel = RSEL_STATUS;
      end else if (a == OFS_TIMER) begin
         sel = RSEL_TIMER;
      end else if (a == OFS_LIMIT) begin
         sel = RSEL_LIMIT;
      end
      return sel;
   endfunction

   // byte-lane merge of write data into a register
   function automatic logic [31:0] csc_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // comparator results pass two flops before use
   csc_sync #(
      .WIDTH($bits(csc_sense_t))
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d(sense),
      .q(s)
   );
   // next-state logic for controller and bus slave
   always_comb begin
      logic permit;       // effective permit level
      logic permit_fall;  // permit falling edge
      logic supply_ok;    // supply valid
      logic temp_start;   // inside start window
      logic temp_run;     // inside running window
      logic start_chg;    // detection finished or battery fell after complete: start charge
      logic fault_hit;    // safety timer expired this cycle
      csc_rsel_t wsel;    // write target
      csc_rsel_t rsel;    // read target
      permit = 1'b0;
      permit_fall = 1'b0;
      supply_ok = 1'b0;
      temp_start = 1'b0;
      temp_run = 1'b0;
      start_chg = 1'b0;
      fault_hit = 1'b0;
      wsel = RSEL_NONE;
      rsel = RSEL_NONE;
      r_next = r_reg;
      // tick prescaler from the oscillator clock
      if (r_reg.presc == 32'(TICK_CYC - 1)) begin
         r_next.presc = '0;
         r_next.tick = 1'b1;
      end else begin
         r_next.presc = r_reg.presc + 32'h0000_0001;
         r_next.tick = 1'b0;
      end
      // permit: pin reads low when undriven, gated by software
      permit = s.charge_permit & r_reg.soft_permit;
      permit_fall = r_reg.permit_d & ~permit;
      r_next.permit_d = permit;
      // supply and temperature qualification
      supply_ok = ~s.supply_undervoltage_lockout & ~s.input_overvoltage
                  & ~s.sleep_mode;
      temp_start = s.ts_above_cold & s.ts_below_hot;
      temp_run = s.ts_above_cold & s.ts_below_cutoff;
      // controller state machine
      if (!supply_ok) begin
         // lockout, overvoltage or sleep: everything parked
         r_next.st = ST_OFF;
         r_next.win = '0;
         r_next.safety = '0;
      end else if (!permit || permit_fall) begin
         // permit low: timers and faults cleared
         r_next.st = ST_HOLD;
         r_next.win = '0;
         r_next.safety = '0;
      end else begin
         case (r_reg.st)
            // supply just became valid or permit returned
            ST_OFF, ST_HOLD: begin
               r_next.st = ST_DISCH;
            end
            // discharge phase of detection
            ST_DISCH: begin
               if (s.bat_below_low_voltage_threshold) begin
                  r_next.st = ST_PROBE;
                  r_next.win = '0;
               end else if (r_reg.tick) begin
                  if (r_reg.win == 16'(DISCH_TICKS - 1)) begin
                     start_chg = 1'b1;
                  end else begin
                     r_next.win = r_reg.win + 16'h0001;
                  end
               end
            end
            // probe-charge phase of detection
            ST_PROBE: begin
               if (s.bat_above_recharge) begin
                  r_next.st = ST_DISCH;
                  r_next.win = '0;
               end else if (r_reg.tick) begin
                  if (r_reg.win == 16'(PROBE_TICKS - 1)) begin
                     start_chg = 1'b1;
                  end else begin
                     r_next.win = r_reg.win + 16'h0001;
                  end
               end
            end
            // waiting for the start window, timer held
            ST_TSUSP: begin
               if (temp_start) begin
                  r_next.st = ST_CHARGE;
               end
            end
            // normal charge with safety timer running
            ST_CHARGE: begin
               if (!temp_run) begin
                  r_next.st = ST_TSUSP;
               end else if (s.charge_term) begin
                  r_next.st = ST_DONE;
               end else if (r_reg.tick && !s.battery_overvoltage
                            && !s.thermal_shutdown) begin
                  if (r_reg.safety >= r_reg.limit - 32'h0000_0001) begin
                     fault_hit = 1'b1;
                  end else begin
                     r_next.safety = r_reg.safety + 32'h0000_0001;
                  end
               end
            end
            // complete; a fallen battery restarts charge
            ST_DONE: begin
               if (!s.bat_above_recharge) begin
                  start_chg = 1'b1;
               end
            end
            // fault latched until battery falls below recharge
            ST_FLT_HI: begin
               if (!s.bat_above_recharge) begin
                  r_next.st = ST_DISCH;
                  r_next.win = '0;
                  r_next.safety = '0;
               end
            end
            // removal probe while battery stays low
            ST_FLT_LO: begin
               if (s.bat_above_recharge) begin
                  r_next.st = ST_FLT_HI;
               end
            end
            // unreachable codes recover to detection
            default: begin
               r_next.st = ST_DISCH;
               r_next.win = '0;
            end
         endcase
         // enter charge, or suspend if out of the start window
         if (start_chg) begin
            r_next.st = temp_start ? ST_CHARGE : ST_TSUSP;
            r_next.win = '0;
            r_next.safety = '0;
         end
         // timer expiry picks the recovery path by battery level
         if (fault_hit) begin
            r_next.st = s.bat_above_recharge ? ST_FLT_HI
                                             : ST_FLT_LO;
         end
      end
      // power stage and status lines follow the next state, except gate drive, supply select and supply valid, which follow the conditions
      r_next.pwr.gate_drive_en = ~s.supply_undervoltage_lockout;
      r_next.pwr.battery_supply_sel = s.input_overvoltage
                                      | s.supply_undervoltage_lockout;
      r_next.pwr.pwm_fets_en = (r_next.st == ST_CHARGE)
                               | (r_next.st == ST_PROBE);
      r_next.pwr.probe_charge_en = (r_next.st == ST_PROBE);
      r_next.pwr.discharge_sink_en = (r_next.st == ST_DISCH);
      r_next.pwr.removal_probe_current_en =
         (r_next.st == ST_FLT_LO);
      r_next.sv_oe = supply_ok;
      r_next.s1_oe = (r_next.st == ST_CHARGE);
      r_next.s2_oe = (r_next.st == ST_DONE);
      // write address and data captured in either order
      if (s_axi_awvalid && r_reg.awready) begin
         r_next.aw_got = 1'b1;
         r_next.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && r_reg.wready) begin
         r_next.w_got = 1'b1;
         r_next.wdata = s_axi_wdata;
         r_next.wstrb = s_axi_wstrb;
      end
      // both held: perform the write and answer
      if (r_reg.aw_got && r_reg.w_got) begin
         wsel = csc_decode(r_reg.awaddr);
         r_next.aw_got = 1'b0;
         r_next.w_got = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp = RESP_OKAY;
         if (wsel == RSEL_CTRL) begin
            if (r_reg.wstrb[0]) begin
               r_next.soft_permit = r_reg.wdata[CTRL_PERMIT_BIT];
            end
         end else if (wsel == RSEL_LIMIT) begin
            r_next.limit = csc_merge(r_reg.limit, r_reg.wdata, r_reg.wstrb);
         end else if (wsel == RSEL_NONE) begin
            r_next.bresp = RESP_SLVERR;
         end
      end
      // write response taken
      if (r_reg.bvalid && s_axi_bready) begin
         r_next.bvalid = 1'b0;
      end
      r_next.awready = ~r_next.aw_got & ~r_next.bvalid;
      r_next.wready = ~r_next.w_got & ~r_next.bvalid;
      // read address taken, data answered next edge
      if (s_axi_arvalid && r_reg.arready) begin
         rsel = csc_decode(s_axi_araddr);
         r_next.rvalid = 1'b1;
         r_next.rresp = RESP_OKAY;
         r_next.rdata = '0;
         if (rsel == RSEL_CTRL) begin
            r_next.rdata[CTRL_PERMIT_BIT] = r_reg.soft_permit;
         end else if (rsel == RSEL_STATUS) begin
            r_next.rdata[STAT_STATE_LSB +: 9] = r_reg.st;
            r_next.rdata[STAT_FAULT_BIT] = (r_reg.st == ST_FLT_HI)
                                           | (r_reg.st == ST_FLT_LO);
            r_next.rdata[STAT_SV_PIN_BIT] = supply_valid_out_i;
            r_next.rdata[STAT_S1_PIN_BIT] = status_line_first_i;
            r_next.rdata[STAT_S2_PIN_BIT] = status_line_second_i;
            r_next.rdata[STAT_PERMIT_BIT] = s.charge_permit;
         end else if (rsel == RSEL_TIMER) begin
            r_next.rdata = r_reg.safety;
         end else if (rsel == RSEL_LIMIT) begin
            r_next.rdata = r_reg.limit;
         end else begin
            r_next.rresp = RESP_SLVERR;
         end
      end
      // read data taken
      if (r_reg.rvalid && s_axi_rready) begin
         r_next.rvalid = 1'b0;
      end
      r_next.arready = ~r_next.rvalid;
   end

   // state register, synchronous reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r_reg <= '0;
         r_reg.st <= ST_OFF;
         r_reg.limit <= 32'(SAFETY_TICKS);
         r_reg.soft_permit <= CTRL_PERMIT_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // outputs straight from the state register; open-drain levels tied low
   assign power = r_reg.pwr;
   assign supply_valid_out_o = 1'b0;
   assign supply_valid_out_oe = r_reg.sv_oe;
   assign status_line_first_o = 1'b0;
   assign status_line_first_oe = r_reg.s1_oe;
   assign status_line_second_o = 1'b0;
   assign status_line_second_oe = r_reg.s2_oe;
   assign s_axi_awready = r_reg.awready;
   assign s_axi_wready = r_reg.wready;
   assign s_axi_bresp = r_reg.bresp;
   assign s_axi_bvalid = r_reg.bvalid;
   assign s_axi_arready = r_reg.arready;
   assign s_axi_rdata = r_reg.rdata;
   assign s_axi_rresp = r_reg.rresp;
   assign s_axi_rvalid = r_reg.rvalid;

endmodule

/* rtl/csc_pkg.sv */
// Overview of operation
// - start charge only inside cold-to-hot window
// - keep charging only inside cold-to-cutoff window
// - temperature suspend turns both power transistors off
// - high-voltage timer fault clears when battery drops
// - permit low or power-on reset clears fault
// - low-voltage timer fault applies removal probe current
// - probe off once battery rises above recharge
// - supply valid output follows supply state
// - charging needs permit high plus all conditions
// - permit falling edge resets timers and faults
// - floating permit input reads as low
// - first line on charging, second on complete
// - both status lines off in other states
// - detection starts with discharge sink after power-up
// - low voltage in discharge window starts probe charge
// - recharge crossing in probe window restarts detection
// - window expiry declares battery and starts charge
// - battery overvoltage pauses safety timer
// - undervoltage lockout disables circuits and gate drives
// - input overvoltage stops charge, selects battery supply
package csc_pkg;

   // clock and time base
   localparam int CLK_MHZ = 125;                   // aclk rate
   localparam int TICK_US = 1000;                  // detection time base
   localparam int TICK_CYCLES = TICK_US * CLK_MHZ; // aclk cycles per tick
   localparam int DISCH_WINDOW_MS = 1000;          // discharge window
   localparam int PROBE_WINDOW_MS = 500;           // probe-charge window
   localparam int DISCH_TICKS = DISCH_WINDOW_MS * 1000 / TICK_US;
   localparam int PROBE_TICKS = PROBE_WINDOW_MS * 1000 / TICK_US;
   localparam int SAFETY_TICKS_DEF = 32'h0112_A880; // safety timer, ticks

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;   // control
   localparam logic [7:0] OFS_STATUS = 8'h04; // status, read only
   localparam logic [7:0] OFS_TIMER = 8'h08;  // safety timer count, read only
   localparam logic [7:0] OFS_LIMIT = 8'h0C;  // safety timer limit

   // field positions
   localparam int CTRL_PERMIT_BIT = 0;    // software charge permit
   localparam int STAT_STATE_LSB = 0;     // one-hot state, 9 bits
   localparam int STAT_FAULT_BIT = 9;     // timer fault latched
   localparam int STAT_SV_PIN_BIT = 10;   // supply-valid pin level
   localparam int STAT_S1_PIN_BIT = 11;   // first status pin level
   localparam int STAT_S2_PIN_BIT = 12;   // second status pin level
   localparam int STAT_PERMIT_BIT = 13;   // synchronised permit input

   // reset values
   localparam logic CTRL_PERMIT_RST = 1'b1;

   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // register selector
   typedef enum logic [2:0] {
      RSEL_NONE = 3'h0,
      RSEL_CTRL = 3'h1,
      RSEL_STATUS = 3'h2,
      RSEL_TIMER = 3'h3,
      RSEL_LIMIT = 3'h4
   } csc_rsel_t;

   // controller states, one-hot
   typedef enum logic [8:0] {
      ST_OFF = 9'h001,    // supply not valid
      ST_HOLD = 9'h002,   // charge not permitted
      ST_DISCH = 9'h004,  // detection, discharge sink on
      ST_PROBE = 9'h008,  // detection, reduced probe charge
      ST_CHARGE = 9'h010, // normal charge
      ST_TSUSP = 9'h020,  // temperature suspend
      ST_DONE = 9'h040,   // charge complete
      ST_FLT_HI = 9'h080, // timer fault, battery above recharge
      ST_FLT_LO = 9'h100  // timer fault, removal probe on
   } csc_state_t;

   // analog comparator and condition inputs
   typedef struct packed {
      logic charge_permit;       // permit pin level
      logic ts_above_cold;       // thermistor warmer than cold limit
      logic ts_below_hot;        // thermistor cooler than hot limit
      logic ts_below_cutoff;     // thermistor cooler than cutoff
      logic bat_above_recharge;  // battery above recharge threshold
      logic bat_below_low_voltage_threshold;      // battery below low voltage threshold
      logic battery_overvoltage; // battery overvoltage
      logic thermal_shutdown;    // die too hot
      logic charge_term;         // charge current termination reached
      logic supply_undervoltage_lockout; // supply below lockout
      logic input_overvoltage;   // adapter above overvoltage threshold
      logic sleep_mode;          // adapter below battery
   } csc_sense_t;

   // power stage controls
   typedef struct packed {
      logic gate_drive_en;       // adapter and battery switch gate bias
      logic battery_supply_sel;  // system fed from battery
      logic pwm_fets_en;         // both switching transistors allowed
      logic probe_charge_en;     // reduced probe charge current
      logic discharge_sink_en;   // sink on battery-side sense terminal
      logic removal_probe_current_en; // removal probe current
   } csc_power_t;

endpackage

/* rtl/csc_sync.sv */
// two-stage synchroniser for comparator levels
module csc_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // levels
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_reg; // first stage, read only by second stage

   // both stages clear on reset; first stage feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end

endmodule

/* verif/csc_pin_model.sv */
// host side of the three open-drain status lines
module csc_pin_model (
   // transistor enables from the controller
   input wire logic [2:0] oe,
   // line levels seen by the host
   output logic [2:0] pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // pull-ups hold a released line high, an on transistor pulls it low
   assign pin = ~oe;
endmodule

/* verif/csc_top_checker.sv */
// port checks for the charge state controller
module csc_top_checker
   import csc_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // watched ports
   input wire csc_sense_t sense,
   input wire csc_power_t power,
   input wire logic supply_valid_out_oe,
   input wire logic status_line_first_oe,
   input wire logic status_line_second_oe
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // normal charge: converter on outside the probe phase
   wire logic chg = power.pwm_fets_en && !power.probe_charge_en;
   // detection leaves the discharge phase in this cycle
   sequence s_left_disch;
      $past(power.discharge_sink_en) && !power.discharge_sink_en;
   endsequence
   AST_SV_OFF: assert property (
      supply_valid_out_oe |-> !$past(sense.supply_undervoltage_lockout
      || sense.input_overvoltage || sense.sleep_mode, 3))
      else $error("supply valid shown while supply bad");
   AST_GATE_SUPPLY_UNDERVOLTAGE_LOCKOUT: assert property (
      power.gate_drive_en |-> !$past(sense.supply_undervoltage_lockout, 3))
      else $error("gate drive on during lockout");
   AST_INPUT_OVERVOLTAGE: assert property (
      $past(sense.input_overvoltage, 3)
      |-> power.battery_supply_sel && !power.pwm_fets_en)
      else $error("input overvoltage not handled");
   AST_TEMP_RUN: assert property (
      chg |-> $past(sense.ts_above_cold && sense.ts_below_cutoff, 3))
      else $error("charging outside temperature range");
   AST_PERMIT: assert property (
      power.pwm_fets_en |-> $past(sense.charge_permit, 3))
      else $error("converter on without permit");
   AST_FIRST: assert property (
      status_line_first_oe |-> chg && !status_line_second_oe)
      else $error("first status line on outside charge");
   AST_QUIET: assert property (
      (power.removal_probe_current_en || power.discharge_sink_en)
      |-> !status_line_first_oe && !status_line_second_oe)
      else $error("status line on while not charging");
   AST_PROBE_ENTRY: assert property (
      $rose(power.probe_charge_en) |-> s_left_disch)
      else $error("probe charge not entered from discharge");
   AST_RMV: assert property (
      power.removal_probe_current_en
      |-> !$past(sense.bat_above_recharge, 3) && !power.pwm_fets_en)
      else $error("removal probe on above recharge");
endmodule
bind csc_top csc_top_checker i_chk (.aclk(aclk), .aresetn(aresetn),
   .sense(sense), .power(power), .supply_valid_out_oe(supply_valid_out_oe),
   .status_line_first_oe(status_line_first_oe),
   .status_line_second_oe(status_line_second_oe));

/* verif/test_charge_state_controller.sv */
// self-checking bench for the charge state controller
module test_charge_state_controller
   import csc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // bus row: request beside the answer it should give
   typedef struct packed {
      logic wr;
      logic [7:0] a;
      logic [31:0] d;
      logic [1:0] rsp;
      logic [31:0] rd;
   } csc_row_t;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic supply_valid_out_o, status_line_first_o, status_line_second_o;
   logic supply_valid_out_oe, status_line_first_oe, status_line_second_oe;
   wire supply_valid_out_i, status_line_first_i, status_line_second_i;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   csc_sense_t sense;
   csc_power_t power;
   int n_errors, n_compared;
   csc_row_t rows [8] = '{'{1'b0, OFS_CTRL, 32'h0, RESP_OKAY, 32'h1},
      '{1'b0, OFS_LIMIT, 32'h0, RESP_OKAY, 32'h32},
      '{1'b1, OFS_LIMIT, 32'hC8, RESP_OKAY, 32'h0},
      '{1'b0, OFS_LIMIT, 32'h0, RESP_OKAY, 32'hC8},
      '{1'b1, OFS_STATUS, 32'hFFFF_FFFF, RESP_OKAY, 32'h0},
      '{1'b0, OFS_STATUS, 32'h0, RESP_OKAY, 32'h1802},
      '{1'b1, 8'h10, 32'h0, RESP_SLVERR, 32'h0},
      '{1'b0, 8'h10, 32'h0, RESP_SLVERR, 32'h0}};
   csc_top #(.TICK_CYC(4), .SAFETY_TICKS(50)) i_dut (.*);
   csc_pin_model i_pins (.oe({supply_valid_out_oe, status_line_first_oe,
      status_line_second_oe}), .pin({supply_valid_out_i,
      status_line_first_i, status_line_second_i}));
   // clock at 8 ns
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // compare and report a mismatch
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // counts, verdict and end of run
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // a wait ran out: count it and close
   task automatic hang(input int n);
      if (n > 1000) begin
         n_errors++;
         give_verdict();
      end
   endtask
   // let n cycles pass, ending off the sampling edge
   task automatic tick(input int n);
      repeat (n) @(negedge aclk);
   endtask
   // one write (wr high) or read; answers looked at off the clock edge
   task automatic axi(input logic wr, input logic [7:0] a,
         input logic [31:0] wd, output logic [31:0] rd,
         output logic [1:0] r);
      int n;
      logic ha, hw, hb;
      @(posedge aclk);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, wd};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
      {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
      hb = 1'b0;
      for (n = 0; !hb; n++) begin
         @(negedge aclk);
         ha = s_axi_awvalid && s_axi_awready
              || s_axi_arvalid && s_axi_arready;
         hw = s_axi_wvalid && s_axi_wready;
         hb = s_axi_bvalid || s_axi_rvalid;
         r = wr ? s_axi_bresp : s_axi_rresp;
         rd = s_axi_rdata;
         hang(n);
         @(posedge aclk);
         if (ha) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
         if (hw) s_axi_wvalid <= 1'b0;
         if (hb) {s_axi_bready, s_axi_rready} <= 2'h0;
      end
   endtask
   // controller state field of the status word
   task automatic st(input string nm, input csc_state_t s);
      logic [31:0] d;
      logic [1:0] r;
      axi(1'b0, OFS_STATUS, 32'h0, d, r);
      chk(nm, 32'(s), 32'(d[8:0]));
   endtask
   // set one condition bit (11 permit .. 0 sleep), let it settle
   task automatic set(input int b, input logic v);
      @(posedge aclk) sense[b] <= v;
      tick(6);
   endtask
   // main sequence
   initial begin
      logic [31:0] d, t;
      logic [1:0] r;
      int n;
      aresetn = 1'b0;
      sense = 12'h700;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
         s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      tick(4);
      chk("reset", 32'h0, 32'({power, s_axi_awready}));
      @(posedge aclk) aresetn <= 1'b1;
      foreach (rows[i]) begin
         axi(rows[i].wr, rows[i].a, rows[i].d, d, r);
         chk("resp", rows[i].rsp, r);
         if (!rows[i].wr) chk("rdata", rows[i].rd, d);
      end
      $display("register test done");
      set(11, 1'b1);
      chk("sink", 32'h1, power.discharge_sink_en);
      st("detect", ST_DISCH);
      set(6, 1'b1);
      st("probe", ST_PROBE);
      set(6, 1'b0);
      set(7, 1'b1);
      st("restart", ST_DISCH);
      set(7, 1'b0);
      tick(DISCH_TICKS * 4 - 46);
      st("window", ST_DISCH);
      tick(80);
      chk("first pin", 32'h0, status_line_first_i);
      st("charge", ST_CHARGE);
      $display("detection test done");
      set(9, 1'b0);
      st("warm", ST_CHARGE);
      set(8, 1'b0);
      chk("fets", 32'h0, {power.pwm_fets_en, status_line_first_oe});
      set(8, 1'b1);
      st("narrow", ST_TSUSP);
      set(9, 1'b1);
      st("resume", ST_CHARGE);
      set(7, 1'b1);
      set(3, 1'b1);
      chk("second pin", 32'h0, status_line_second_i);
      set(3, 1'b0);
      set(7, 1'b0);
      st("recharge", ST_CHARGE);
      $display("temperature test done");
      set(5, 1'b1);
      axi(1'b0, OFS_TIMER, 32'h0, t, r);
      tick(40);
      axi(1'b0, OFS_TIMER, 32'h0, d, r);
      chk("pause", t, d);
      set(5, 1'b0);
      for (n = 0; power.removal_probe_current_en !== 1'b1; n++) begin
         hang(n);
         @(negedge aclk);
      end
      st("fault low", ST_FLT_LO);
      set(7, 1'b1);
      chk("probe off", 32'h0, power.removal_probe_current_en);
      st("fault high", ST_FLT_HI);
      set(7, 1'b0);
      st("recover", ST_DISCH);
      set(11, 1'b0);
      axi(1'b0, OFS_TIMER, 32'h0, d, r);
      chk("timer clear", 32'h0, d);
      st("held", ST_HOLD);
      $display("fault test done");
      for (int i = 0; i < 3; i++) begin
         set(i, 1'b1);
         chk("sv pin", 32'h1, supply_valid_out_i);
         chk("gate", 32'(i != 2), power.gate_drive_en);
         chk("sel", 32'(i != 0), power.battery_supply_sel);
         set(i, 1'b0);
      end
      $display("supply test done");
      give_verdict();
   end
endmodule
